// [sram_pkg.sv]
// Package: timing and encodings for the async SRAM host controller.
// Assumes a 10 MHz reference clock; timings are for the slowest grade.
package sram_pkg;
  localparam int CLK_PERIOD_NS   = 100;
  // Slowest speed grade figures, in ns
  localparam int READ_CYCLE_NS   = 100;
  localparam int ADDR_TO_DATA_MAX = 100;
  localparam int OE_TO_DATA_NS   = 40;
  localparam int HIZ_MAX_NS      = 40;
  localparam int SEL_TO_END_NS   = 80;
  localparam int ADDR_TO_END_NS  = 80;
  localparam int WRITE_PULSE_NS  = 55;
  localparam int WRITE_CYCLE_NS  = 100;
  localparam int DATA_OVERLAP_MIN = 40;
  localparam int DATA_HOLD_AFTER_STROBE = 0;
  localparam int DATA_HOLD_AFTER_SELECT = 3;
  localparam int RECOVERY_NS     = 0;
  // Least times round up, at least one cycle
  function automatic int ns_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int MAX2_A = (WRITE_PULSE_NS > HIZ_MAX_NS + DATA_OVERLAP_MIN) ? WRITE_PULSE_NS
                          : HIZ_MAX_NS + DATA_OVERLAP_MIN;
  localparam int READ_CYC   = ns_up(READ_CYCLE_NS);
  localparam int HIZ_CYC    = ns_up(HIZ_MAX_NS);
  localparam int WP_OE_CYC  = ns_up(MAX2_A);
  localparam int WP_CYC     = ns_up(WRITE_PULSE_NS);
  localparam int SEL_CYC    = ns_up(SEL_TO_END_NS);
  localparam int HOLD_CYC   = ns_up(DATA_HOLD_AFTER_SELECT);
  localparam int CNT_W      = 4;
  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_TURN, ST_WR, ST_HOLD} state_t;
endpackage

// [sram_req_if.sv]
// Interface: request/answer bundle between controller sequencer and timer.
// Assumes one clock domain.
`timescale 1ns/100ps
interface sram_req_if;
  logic [3:0] load;
  logic       start;
  logic       done;
  modport seq (output load, output start, input done);
  modport tmr (input load, input start, output done);
endinterface

// [sram_timer.sv]
// Timer: down-counter that raises done when a loaded cycle count expires.
// Assumes start is a one-cycle pulse.
`timescale 1ns/100ps
module sram_timer (
  input wire logic clk,
  input wire logic rst,
  sram_req_if.tmr  req
);
  import sram_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } tmr_t;
  tmr_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (req.start) begin
      s_nxt.cnt = req.load;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
      if (s_r.cnt == 4'h1) s_nxt.done = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign req.done = s_r.done;
endmodule

// [sram_host.sv]
// Host controller for an asynchronous byte-wide SRAM with select, strobe and output enable.
// Assumes REQ inputs synchronous to REF_CLK; the memory data bus is shared, resolved outside.
// One request is served at a time; each access spans several reference clocks.
// Timing counts are whole reference cycles, rounded up from the slowest grade.
// Behaviour
// R01: Strobe stays high through every read.
// R02: Memory gives data on address change.
// R03: Address valid before select falls.
// R04: Write happens while select and strobe low.
// R05: Address changes only with strobe high.
// R06: Recovery counted from strobe rise, zero minimum.
// R07: No drive while memory still drives.
// R08: Select falls with strobe for high-Z.
// R09: Strobe pulse covers turn-off plus overlap.
// R10: Output disabled permits minimum strobe pulse.
// R11: Read data valid within select access.
// R12: Read data valid after enable time.
// R13: Memory releases bus after deselect.
// R14: Memory drives no sooner than 5 ns.
// R15: Old data held 5 ns after change.
// R16: Select low long enough before write end.
// R17: Address valid long enough before write end.
// R18: Data stable before end, pulse minimum.
// R19: Data held after strobe and select rise.
// R20: Memory waits 5 ns before redriving.
// R21: Overlap time depends on temperature grade.
// R22: Memory floats outputs after strobe falls.
// R23: Address and data widths are parameters.
`timescale 1ns/100ps
module sram_host #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          REF_CLK,
  input  wire logic          RST,
  // User request
  input  wire logic          REQ_VALID,
  input  wire logic          REQ_WRITE,
  input  wire logic          REQ_OE_LOW,
  input  wire logic [AW-1:0] REQ_ADDR,
  input  wire logic [DW-1:0] REQ_WDATA,
  output logic               REQ_READY,
  // Read answer
  output logic               RSP_VALID,
  output logic [DW-1:0]      RSP_RDATA,
  // Memory pins
  output logic [AW-1:0]      MEM_ADDR,
  output logic               MEM_SEL_N,
  output logic               MEM_WSTB_N,
  output logic               MEM_OE_N,
  // Memory data bus, split into its two directions
  output logic [DW-1:0]      MEM_DQ_O,
  output logic               MEM_DQ_OE,
  input  wire logic [DW-1:0] MEM_DQ_I
);
  import sram_pkg::*;
  // Each timer load must fit the four-bit counter and be at least one,
  // or the sequencer would wait for a done that never comes
  if (AW < 1) begin : g_bad_aw
    $error("sram_host: address width below one");
  end
  if (DW < 1) begin : g_bad_dw
    $error("sram_host: data width below one");
  end
  if (CNT_W != 4) begin : g_bad_cnt
    $error("sram_host: timer width differs from the request bundle");
  end
  if (READ_CYC > 14) begin : g_bad_rd
    $error("sram_host: read time exceeds the timer");
  end
  if (WP_OE_CYC > 15 || WP_CYC > 15 || SEL_CYC > 15) begin : g_bad_wr
    $error("sram_host: write time exceeds the timer");
  end
  if (HIZ_CYC > 15 || HOLD_CYC > 15) begin : g_bad_rec
    $error("sram_host: recovery time exceeds the timer");
  end
  // Timer loads, cut to the counter width on purpose after the checks above
  localparam logic [3:0] TURN_LOAD = 4'h1;
  localparam logic [3:0] RD_LOAD   = 4'(READ_CYC + 1);
  localparam logic [3:0] HIZ_LOAD  = 4'(HIZ_CYC);
  localparam logic [3:0] HOLD_LOAD = 4'(HOLD_CYC);
  // All sequencer state except the timer count; every pin is taken straight from these flops
  typedef struct packed {
    state_t          st;
    logic            wr_oe;
    logic            ready;
    logic            rvalid;
    logic [DW-1:0]   rdata;
    logic [AW-1:0]   addr;
    logic            sel_n;
    logic            wstb_n;
    logic            oe_n;
    logic [DW-1:0]   dq_o;
    logic            dq_oe;
  } host_t;
  host_t s_r, s_nxt;
  sram_req_if req ();
  logic [3:0] ld;
  logic       go;
  assign req.load  = ld;
  assign req.start = go;
  // One timer serves every phase; each phase reloads it on entry
  sram_timer u_tmr (
    .clk (REF_CLK),
    .rst (RST),
    .req (req)
  );
  // Longest of pulse width and select-to-end, output-enable dependent
  function automatic logic [3:0] wr_len(input logic oe_low);
    int n;
    n = oe_low ? WP_OE_CYC : WP_CYC; // R09 R10 R21
    if (SEL_CYC > n) n = SEL_CYC; // R16 R17 R18
    return n[3:0];
  endfunction
  // Sequencer: one access at a time, each phase timed by the shared timer
  always_comb begin
    s_nxt = s_r;
    ld = '0;
    go = 1'b0;
    s_nxt.rvalid = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (REQ_VALID && s_r.ready) begin
          s_nxt.ready = 1'b0;
          // Address moves while both select and strobe are high
          s_nxt.addr  = REQ_ADDR; // R03 R05 R17 R23
          s_nxt.sel_n = 1'b1;
          s_nxt.wstb_n = 1'b1; // R01
          go = 1'b1;
          if (REQ_WRITE) begin
            // Keeping output enable low needs more ns of strobe, but both round to the same timer load
            s_nxt.wr_oe = REQ_OE_LOW;
            s_nxt.oe_n  = ~REQ_OE_LOW;
            // Data is loaded early but driven only once the memory has floated
            s_nxt.dq_o  = REQ_WDATA;
            ld = TURN_LOAD;
            s_nxt.st = ST_TURN;
          end else begin
            // Output enable goes low with the address; select follows a cycle later
            s_nxt.oe_n = 1'b0;
            ld = RD_LOAD;
            s_nxt.st = ST_RD;
          end
        end
      end
      ST_RD: begin
        // Select low for the read cycle plus one more cycle before the sample covers both access times
        s_nxt.sel_n = 1'b0; // R02 R03 R14
        if (req.done) begin
          // Sample before deselect; full access time has passed
          s_nxt.rdata  = MEM_DQ_I; // R11 R12 R15
          s_nxt.rvalid = 1'b1;
          s_nxt.sel_n  = 1'b1;
          s_nxt.oe_n   = 1'b1;
          ld = HIZ_LOAD;
          go = 1'b1;
          s_nxt.st = ST_HOLD; // R13
        end
      end
      ST_TURN: begin
        // Address has settled two cycles with both controls high before the write opens
        if (req.done) begin
          // Select and strobe fall together so the memory never drives
          s_nxt.sel_n  = 1'b0; // R08 R22
          s_nxt.wstb_n = 1'b0; // R04
          ld = wr_len(s_r.wr_oe);
          go = 1'b1;
          s_nxt.st = ST_WR;
        end
      end
      ST_WR: begin
        // Drive data only once strobe is low and the memory has floated
        s_nxt.dq_oe = 1'b1; // R07
        if (req.done) begin
          s_nxt.wstb_n = 1'b1; // R06
          s_nxt.sel_n  = 1'b1;
          ld = HOLD_LOAD;
          go = 1'b1;
          s_nxt.st = ST_HOLD; // R19
        end
      end
      ST_HOLD: begin
        if (req.done) begin
          // Release before the memory can redrive
          s_nxt.dq_oe = 1'b0; // R20
          s_nxt.oe_n  = 1'b1;
          s_nxt.ready = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      // Controls rest high so a reset in mid-write never stores a stray word
      s_r.st     <= ST_IDLE;
      s_r.wr_oe  <= 1'b0;
      s_r.ready  <= 1'b1;
      s_r.rvalid <= 1'b0;
      s_r.rdata  <= '0;
      s_r.addr   <= '0;
      s_r.sel_n  <= 1'b1;
      s_r.wstb_n <= 1'b1;
      s_r.oe_n   <= 1'b1;
      s_r.dq_o   <= '0;
      s_r.dq_oe  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // Pins come straight from flops, so no decode glitch reaches the memory
  assign REQ_READY  = s_r.ready;
  assign RSP_VALID  = s_r.rvalid;
  assign RSP_RDATA  = s_r.rdata;
  assign MEM_ADDR   = s_r.addr;
  assign MEM_SEL_N  = s_r.sel_n;
  assign MEM_WSTB_N = s_r.wstb_n;
  assign MEM_OE_N   = s_r.oe_n;
  assign MEM_DQ_O   = s_r.dq_o;
  assign MEM_DQ_OE  = s_r.dq_oe;
endmodule

// [sram_host_chk.sv]
// Checker: pin timing of the SRAM host controller.
// Assumes it is bound into sram_host, one clock.
`timescale 1ns/100ps
module sram_host_chk #(parameter int AW = 15, parameter int DW = 8) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Request side
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  // Memory pins
  input wire logic [AW-1:0] MEM_ADDR,
  input wire logic MEM_SEL_N,
  input wire logic MEM_WSTB_N,
  input wire logic MEM_OE_N,
  input wire logic [DW-1:0] MEM_DQ_O,
  input wire logic MEM_DQ_OE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_read_strobe: assert property (RSP_VALID |-> $past(MEM_WSTB_N) && $past(MEM_WSTB_N, 2))
    else $error("strobe low in read");
  a_addr_at_sel: assert property ($fell(MEM_SEL_N) |-> $stable(MEM_ADDR))
    else $error("address moved at select");
  a_addr_guard: assert property (!$stable(MEM_ADDR) |->
    (MEM_WSTB_N || MEM_SEL_N) && ($past(MEM_WSTB_N) || $past(MEM_SEL_N))) else $error("address moved in write");
  a_no_clash: assert property (!MEM_SEL_N && !MEM_OE_N && MEM_WSTB_N |-> !MEM_DQ_OE)
    else $error("bus clash");
  a_float_first: assert property ($fell(MEM_WSTB_N) |-> $fell(MEM_SEL_N) && !MEM_DQ_OE)
    else $error("write start order");
  a_end_setup: assert property ($rose(MEM_WSTB_N) |-> $past(MEM_DQ_OE) && !$past(MEM_SEL_N)
    && $stable(MEM_ADDR) && $stable(MEM_DQ_O)) else $error("write end setup");
  a_data_hold: assert property ($rose(MEM_SEL_N) && $past(MEM_DQ_OE) |-> MEM_DQ_OE && $stable(MEM_DQ_O))
    else $error("data hold");
  a_read_answer: assert property (REQ_VALID && REQ_READY && !REQ_WRITE |-> ##4 RSP_VALID)
    else $error("read answer late");
  c_read: cover property (RSP_VALID);
  c_write_oe: cover property ($fell(MEM_WSTB_N) && !MEM_OE_N);
  c_write_end: cover property ($rose(MEM_WSTB_N));
endmodule
bind sram_host sram_host_chk #(.AW(AW), .DW(DW)) u_chk (
  .REF_CLK    (REF_CLK),
  .RST        (RST),
  .REQ_VALID  (REQ_VALID),
  .REQ_WRITE  (REQ_WRITE),
  .REQ_READY  (REQ_READY),
  .RSP_VALID  (RSP_VALID),
  .MEM_ADDR   (MEM_ADDR),
  .MEM_SEL_N  (MEM_SEL_N),
  .MEM_WSTB_N (MEM_WSTB_N),
  .MEM_OE_N   (MEM_OE_N),
  .MEM_DQ_O   (MEM_DQ_O),
  .MEM_DQ_OE  (MEM_DQ_OE)
);

// [sram_mem_model.sv]
// Partner: behavioural byte-wide static RAM seen at its pins.
// Assumes active-low controls and no pull on the data lines.
`timescale 1ns/100ps
module sram_mem_model #(parameter int AW = 15, parameter int DW = 8, parameter int DLY = 40) (
  // Memory pins
  input wire logic [AW-1:0] addr,
  input wire logic sel_n,
  input wire logic wstb_n,
  input wire logic oe_n,
  input wire logic [DW-1:0] din,
  output logic [DW-1:0] dout
);
  logic [DW-1:0] mem [logic [AW-1:0]];
  logic [AW-1:0] wa;
  logic [DW-1:0] wd;
  wire wr = !sel_n && !wstb_n;
  wire drv = !sel_n && !oe_n && wstb_n;
  initial dout = '0;
  always @* if (wr) begin
    wa = addr;
    wd = din;
  end
  // Stored on the first rise of either strobe; unknown startup edges ignored
  always @(negedge wr) if (!$isunknown(wa)) mem[wa] = wd;
  // Slow answer; a released bus never holds its last value
  always @(addr or drv) begin
    if (drv) dout <= #DLY (mem.exists(addr) ? mem[addr] : ~dout);
    else dout = ~dout;
  end
endmodule

// [testbench.sv]
// Testbench: random writes and read-backs through the host into a memory model.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/100ps
module testbench;
  logic REF_CLK = 0, RST = 1, REQ_VALID = 0, REQ_WRITE = 0, REQ_OE_LOW = 0;
  logic [14:0] REQ_ADDR = '0, MEM_ADDR;
  logic [7:0] REQ_WDATA = '0, RSP_RDATA, MEM_DQ_O, MEM_DQ_I;
  logic REQ_READY, RSP_VALID, MEM_SEL_N, MEM_WSTB_N, MEM_OE_N, MEM_DQ_OE;
  logic [7:0] ref_mem [logic [14:0]];
  logic [7:0] exp_q [$];
  logic [14:0] aq [$];
  int fail_count = 0, compares = 0;
  initial forever #50 REF_CLK = ~REF_CLK;
  sram_host i_dut (.REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
    .REQ_OE_LOW(REQ_OE_LOW), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_SEL_N(MEM_SEL_N),
    .MEM_WSTB_N(MEM_WSTB_N), .MEM_OE_N(MEM_OE_N), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE),
    .MEM_DQ_I(MEM_DQ_I));
  sram_mem_model i_mem (.addr(MEM_ADDR), .sel_n(MEM_SEL_N), .wstb_n(MEM_WSTB_N), .oe_n(MEM_OE_N),
    .din(MEM_DQ_OE ? MEM_DQ_O : 8'hZZ), .dout(MEM_DQ_I));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic conclude;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic op(input logic w, input logic [14:0] ad, input logic [7:0] d, input logic oe);
    int n;
    logic rdy;
    n = 0;
    @(posedge REF_CLK);
    #10;
    REQ_VALID = 1;
    REQ_WRITE = w;
    REQ_ADDR = ad;
    REQ_WDATA = d;
    REQ_OE_LOW = oe;
    // Ready is read off the edge; the request stands through the edge that follows a high read
    rdy = REQ_READY;
    while (rdy !== 1'b1 && n < 30) begin
      @(posedge REF_CLK);
      #10 rdy = REQ_READY;
      n++;
    end
    fail_count += (n == 30);
    if (n == 30) conclude();
    @(posedge REF_CLK);
    #10 REQ_VALID = 0;
    if (w) ref_mem[ad] = d;
    else exp_q.push_back(ref_mem[ad]);
  endtask
  task automatic drain;
    for (int n = 0; n < 40 && exp_q.size() > 0; n++) @(posedge REF_CLK);
    fail_count += (exp_q.size() > 0);
    if (exp_q.size() > 0) conclude();
  endtask
  always @(negedge REF_CLK) if (RSP_VALID === 1'b1) chk(RSP_RDATA, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  initial begin
    void'($urandom(32'h0A44));
    repeat (20) @(posedge REF_CLK);
    #10 RST = 0;
    for (int i = 0; i < 10; i++) begin
      aq.push_back(i == 0 ? 15'h0000 : i == 1 ? 15'h7FFF : 15'($urandom));
      op(1'b1, aq[i], 8'($urandom), i[0]);
      op(1'b0, aq[i], 8'h00, 1'b0);
    end
    foreach (aq[i]) op(1'b0, aq[i], 8'h00, 1'b0);
    drain();
    op(1'b1, 15'h1234, 8'hA5, 1'b0);
    #100 RST = 1;
    repeat (3) @(posedge REF_CLK);
    chk({REQ_READY, MEM_SEL_N, MEM_WSTB_N, MEM_OE_N, MEM_DQ_OE}, 32'h1E);
    #10 RST = 0;
    op(1'b0, aq[0], 8'h00, 1'b0);
    drain();
    conclude();
  end
endmodule
